// [adcr_regs.vh]
// Purpose: Shared constants for the converter ready strobe and serial readout.
// Assumes: All counts are in master clock periods unless named otherwise.
// Notes: Definitions only; included by bare name.
`ifndef ADCR_REGS_VH
`define ADCR_REGS_VH

// ----------------------------------------------------------------
// Word format
// ----------------------------------------------------------------
`define ADCR_WORD_BITS      24
`define ADCR_FIFO_DEPTH     16
`define ADCR_FIFO_AW        4

// ----------------------------------------------------------------
// Pacing and settling, in master clock periods
// ----------------------------------------------------------------
`define ADCR_MCLK_PER_N     8
`define ADCR_SETTLE_PER_N   592
`define ADCR_SETTLE_ADD     2
`define ADCR_DECIM_N        3'h1

// ----------------------------------------------------------------
// Pin reset levels, packed as {chain, sync, sclk, cs, mclk}
// ----------------------------------------------------------------
`define ADCR_PIN_COUNT      5
`define ADCR_PIN_RST        5'h0a

`endif

// [adcr_pin_sync.v]
// Purpose: Three-stage synchroniser for pins from outside the clock domain.
// Assumes: Each pin changes slower than two clock periods.
// Notes: A new level is accepted only once stages two and three agree.
`timescale 1ns/100ps

module adcr_pin_sync #(
	parameter         WIDTH   = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] pinIn,
	output reg  [WIDTH-1:0] level
);

	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;

	// ----------------------------------------------------------------
	// Stages and agreement filter
	// ----------------------------------------------------------------
	// Stage one feeds only stage two, so metastability never reaches logic.
	always @(posedge clk) begin
		if (rst) begin
			stage1 <= RST_VAL;
			stage2 <= RST_VAL;
			stage3 <= RST_VAL;
			level  <= RST_VAL;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
			level  <= (stage2 & ~(stage2 ^ stage3)) | (level & (stage2 ^ stage3));
		end
	end

endmodule

// [adcr_fifo.v]
// Purpose: Word FIFO between the sample source and the serial readout.
// Assumes: Single clock; valid and ready handshake on both sides.
// Notes: Full and empty come from pointers one bit wider than the address.
`timescale 1ns/100ps

module adcr_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	output wire [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wrPtr;
	reg [AW:0]      rdPtr;

	wire            empty = (wrPtr == rdPtr);
	wire            full  = (wrPtr[AW-1:0] == rdPtr[AW-1:0]) && (wrPtr[AW] != rdPtr[AW]);
	wire            doWr  = inValid && !full;
	wire            doRd  = outReady && !empty;

	assign inReady  = !full;
	assign outValid = !empty;
	assign outData  = mem[rdPtr[AW-1:0]];

	// ----------------------------------------------------------------
	// Storage and pointers
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (doWr) begin
			mem[wrPtr[AW-1:0]] <= inData;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			wrPtr <= {(AW+1){1'b0}};
			rdPtr <= {(AW+1){1'b0}};
		end else begin
			if (doWr) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (doRd) begin
				rdPtr <= rdPtr + 1'b1;
			end
		end
	end

endmodule

// [adcr_readout.v]
// Purpose: Ready strobe pacing, settling and serial readout of converter words.
// Assumes: clk at 40 MHz; all pins are asynchronous and pass the synchroniser.
// Notes: Serial clock edges closer than two clk periods (50 ns) apart cannot be resolved.
`timescale 1ns/100ps
`include "adcr_regs.vh"

module adcr_readout #(
	parameter [2:0] DECIM_N = `ADCR_DECIM_N
) (
	input  wire                       clk,
	input  wire                       rst,
	input  wire [`ADCR_WORD_BITS-1:0] sampleData,
	input  wire                       sampleValid,
	output wire                       sampleReady,
	input  wire                       mclk,
	input  wire                       csN,
	input  wire                       sclk,
	input  wire                       syncPowerdownN,
	input  wire                       chainIn,
	output reg                        readyStrobeN,
	output reg                        serialOut,
	output reg                        serialOutEn,
	output reg                        settled
);

	// ----------------------------------------------------------------
	// Constants and states
	// ----------------------------------------------------------------
	localparam integer PERIOD_I = DECIM_N * `ADCR_MCLK_PER_N;
	localparam integer SETTLE_I = DECIM_N * `ADCR_SETTLE_PER_N + `ADCR_SETTLE_ADD;
	localparam [5:0]  PERIOD    = PERIOD_I[5:0];
	localparam [11:0] SETTLE    = SETTLE_I[11:0];
	localparam [1:0]  ST_PD     = 2'h0;
	localparam [1:0]  ST_SETTLE = 2'h1;
	localparam [1:0]  ST_RUN    = 2'h2;

	function rising;
		input cur;
		input prev;
		begin
			rising = cur & ~prev;
		end
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	wire [`ADCR_PIN_COUNT-1:0] pins;
	reg                        mclkPrev;
	reg                        sclkPrev;
	wire                       mclkLvl  = pins[0];
	wire                       csLvlN   = pins[1];
	wire                       sclkLvl  = pins[2];
	wire                       syncLvlN = pins[3];
	wire                       chainLvl = pins[4];
	wire                       mclkRise = rising(mclkLvl, mclkPrev);
	wire                       sclkFall = rising(sclkPrev, sclkLvl);

	adcr_pin_sync #(
		.WIDTH   (`ADCR_PIN_COUNT),
		.RST_VAL (`ADCR_PIN_RST)
	) u_sync (
		.clk   (clk),
		.rst   (rst),
		.pinIn ({chainIn, syncPowerdownN, sclk, csN, mclk}),
		.level (pins)
	);

	always @(posedge clk) begin
		if (rst) begin
			mclkPrev <= 1'b0;
			sclkPrev <= 1'b0;
		end else begin
			mclkPrev <= mclkLvl;
			sclkPrev <= sclkLvl;
		end
	end

	// ----------------------------------------------------------------
	// Conversion word buffer
	// ----------------------------------------------------------------
	wire [`ADCR_WORD_BITS-1:0] wordData;
	wire                       wordValid;
	reg                        wordTake;

	adcr_fifo #(
		.WIDTH (`ADCR_WORD_BITS),
		.DEPTH (`ADCR_FIFO_DEPTH),
		.AW    (`ADCR_FIFO_AW)
	) u_fifo (
		.clk      (clk),
		.rst      (rst),
		.inData   (sampleData),
		.inValid  (sampleValid),
		.inReady  (sampleReady),
		.outData  (wordData),
		.outValid (wordValid),
		.outReady (wordTake)
	);

	// ----------------------------------------------------------------
	// Pacing state machine
	// ----------------------------------------------------------------
	reg [1:0]  state;
	reg [1:0]  next_state;
	reg [11:0] settleCnt;
	reg [11:0] next_settleCnt;
	reg [5:0]  phase;
	reg [5:0]  next_phase;
	reg        next_strobeN;
	reg        loadWord;

	always @* begin
		next_state     = state;
		next_settleCnt = settleCnt;
		next_phase     = phase;
		next_strobeN   = readyStrobeN;
		loadWord       = 1'b0;
		wordTake       = 1'b0;
		if (mclkRise) begin
			if (!syncLvlN) begin
				next_state   = ST_PD;
				next_strobeN = 1'b1;
			end else begin
				case (state)
				ST_PD: begin
					next_state     = ST_SETTLE;
					next_settleCnt = 12'h001;
				end
				ST_SETTLE: begin
					next_settleCnt = settleCnt + 12'h001;
					if (settleCnt >= SETTLE - 12'h001) begin
						next_state = ST_RUN;
						next_phase = PERIOD - 6'h01;
					end
				end
				ST_RUN: begin
					if (phase == PERIOD - 6'h01) begin
						next_phase = 6'h00;
						if (wordValid) begin
							loadWord     = 1'b1;
							wordTake     = 1'b1;
							next_strobeN = 1'b0;
						end
					end else begin
						next_phase = phase + 6'h01;
						if (phase == PERIOD - 6'h02) begin
							next_strobeN = 1'b1;
						end
					end
				end
				default: begin
					next_state = ST_PD;
				end
				endcase
			end
		end
	end

	// Reset starts settling directly, since the filter restarts either way.
	always @(posedge clk) begin
		if (rst) begin
			state        <= ST_SETTLE;
			settleCnt    <= 12'h000;
			phase        <= 6'h00;
			readyStrobeN <= 1'b1;
			settled      <= 1'b0;
		end else begin
			state        <= next_state;
			settleCnt    <= next_settleCnt;
			phase        <= next_phase;
			readyStrobeN <= next_strobeN;
			settled      <= (next_state == ST_RUN);
		end
	end

	// ----------------------------------------------------------------
	// Serial shifter
	// ----------------------------------------------------------------
	reg [`ADCR_WORD_BITS-1:0] shift;

	always @(posedge clk) begin
		if (rst) begin
			shift       <= {`ADCR_WORD_BITS{1'b0}};
			serialOut   <= 1'b0;
			serialOutEn <= 1'b0;
		end else begin
			serialOutEn <= !csLvlN;
			if (loadWord) begin
				shift     <= wordData;
				serialOut <= wordData[`ADCR_WORD_BITS-1];
			end else if (sclkFall && !csLvlN) begin
				shift     <= {shift[`ADCR_WORD_BITS-2:0], chainLvl};
				serialOut <= shift[`ADCR_WORD_BITS-2];
			end
		end
	end

endmodule

// [adcr_readout_chk.sv]
// Purpose: Port assertions for the converter readout.
// Assumes: One clock domain; pins change on clk edges.
// Notes: Latency bounds allow for the pin synchroniser.
`timescale 1ns/100ps
module adcr_readout_chk #(
	parameter [2:0] DECIM_N = 3'h1
) (
	input wire clk,
	input wire rst,
	input wire mclk,
	input wire csN,
	input wire sclk,
	input wire syncPowerdownN,
	input wire readyStrobeN,
	input wire serialOut,
	input wire serialOutEn
);
	localparam int SETTLE = 592 * DECIM_N + 2;
	localparam int LOWN = 8 * DECIM_N - 1;
	reg	mQ = 1'b0;
	reg	sQ = 1'b0;
	reg [5:0]	mAge = 6'h3f;
	reg [5:0]	sAge = 6'h3f;
	reg [4:0]	lowRises = 5'h0;
	reg [11:0]	setRises = 12'h0;
	wire	mRise = mclk && !mQ;
	// Ages saturate so that a silent pin can never look recent.
	always @(posedge clk) begin
		mQ <= mclk;
		sQ <= sclk;
		mAge <= mRise ? 6'h0 : mAge + {5'h0, mAge != 6'h3f};
		sAge <= (sQ && !sclk) ? 6'h0 : sAge + {5'h0, sAge != 6'h3f};
		lowRises <= readyStrobeN ? 5'h0 : lowRises + {4'h0, mRise};
		setRises <= (rst || !syncPowerdownN) ? 12'h0 :
			setRises + {11'h0, mRise && setRises != 12'hfff};
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Sync must already be low for a while, so the synchronised level sees it at the rise.
	sequence s_pdEntry; (!syncPowerdownN) [*6] ##0 (mAge == 6'h0); endsequence
	sequence s_pdHeld; !syncPowerdownN [*8]; endsequence
	property p_pdHigh; s_pdEntry ##1 s_pdHeld |-> readyStrobeN; endproperty
	property p_csHi; csN [*8] |-> !serialOutEn; endproperty
	property p_csLo; !csN [*8] |-> serialOutEn; endproperty
	property p_strobeEdge; $changed(readyStrobeN) |-> mAge <= 6'ha; endproperty
	property p_sdoEdge;
		serialOutEn && $changed(serialOut) && $stable(readyStrobeN) |-> sAge <= 6'h8;
	endproperty
	property p_lowLen; $rose(readyStrobeN) && syncPowerdownN |-> lowRises == LOWN; endproperty
	property p_highLen; $rose(readyStrobeN) && syncPowerdownN |=> readyStrobeN [*8]; endproperty
	property p_settle; $fell(readyStrobeN) |-> setRises >= SETTLE; endproperty
	a_pdHigh: assert property (p_pdHigh) else $error("strobe low in power-down");
	a_csHi: assert property (p_csHi) else $error("driving while deselected");
	a_csLo: assert property (p_csLo) else $error("not driving while selected");
	a_strobeEdge: assert property (p_strobeEdge) else $error("strobe moved alone");
	a_sdoEdge: assert property (p_sdoEdge) else $error("data moved alone");
	a_lowLen: assert property (p_lowLen) else $error("strobe low length");
	a_highLen: assert property (p_highLen) else $error("strobe high length");
	a_settle: assert property (p_settle) else $error("strobe before settling");
endmodule
bind adcr_readout adcr_readout_chk #(.DECIM_N(DECIM_N)) u_chk (.clk(clk), .rst(rst),
	.mclk(mclk), .csN(csN), .sclk(sclk), .syncPowerdownN(syncPowerdownN),
	.readyStrobeN(readyStrobeN), .serialOut(serialOut), .serialOutEn(serialOutEn));

// [adcr_host_model.sv]
// Purpose: Host model making the master clock and reading words.
// Assumes: A read starts at a ready strobe fall when enabled.
// Notes: Serial clock period is eight clk cycles and idles low.
`timescale 1ns/100ps
module adcr_host_model (
	input wire	clk,
	input wire	strobeN,
	input wire	sdoLine,
	input wire	readEn,
	input wire [5:0]	nBits,
	output reg	mclk = 1'b0,
	output reg	csN = 1'b1,
	output reg	sclk = 1'b0,
	output reg	chainIn = 1'b0,
	output reg [31:0]	got = 32'h0,
	output reg [7:0]	readCount = 8'h0
);
	reg [5:0]	mCnt = 6'h10;
	reg [7:0]	tCnt = 8'h0;
	reg [5:0]	left = 6'h0;
	reg [3:0]	chainSr = 4'h0;
	reg	sQ = 1'b1;
	// Data is taken at the falling edge, three clk cycles after the readout last changes it.
	always @(posedge clk) begin
		mCnt <= (mCnt == 6'h27) ? 6'h0 : mCnt + 6'h1;
		mclk <= (mCnt < 6'h08);
		sQ <= strobeN;
		tCnt <= tCnt + 8'h1;
		if (csN && readEn && sQ && !strobeN) begin
			csN <= 1'b0;
			tCnt <= 8'h0;
			left <= nBits;
			chainSr <= 4'hb;
		end else if (!csN && left == 6'h0 && tCnt[2:0] == 3'h7) begin
			csN <= 1'b1;
			readCount <= readCount + 8'h1;
		end else if (!csN && tCnt >= 8'h08 && tCnt[2:0] == 3'h0) begin
			sclk <= 1'b1;
			chainIn <= chainSr[3];
		end else if (sclk && tCnt[2:0] == 3'h4) begin
			sclk <= 1'b0;
			got <= {got[30:0], sdoLine};
			left <= left - 6'h1;
			chainSr <= chainSr << 1;
		end
	end
endmodule

// [adcr_readout_test.sv]
// Purpose: Self-checking bench for the converter readout.
// Assumes: n is 1, master clock 1 MHz, serial clock 200 ns.
// Notes: A released data line reads as a toggling level.
`timescale 1ns/100ps
module adcr_readout_test;
	reg	clk = 1'b0;
	reg	rst = 1'b1;
	reg [23:0]	sampleData = 24'h0;
	reg	sampleValid = 1'b0;
	reg	syncPowerdownN = 1'b1;
	reg	readEn = 1'b0;
	reg [5:0]	nBits = 6'h18;
	reg	lastSdo = 1'b0;
	reg	mQ = 1'b0;
	reg [11:0]	riseCnt = 12'h0;
	integer	errCount = 0;
	integer	checksDone = 0;
	integer	fallAt = 0;
	integer	i;
	wire	sampleReady, mclk, csN, sclk, chainIn, readyStrobeN, serialOut, serialOutEn, settled;
	wire [31:0]	got;
	wire [7:0]	readCount;
	wire	sdoLine = serialOutEn ? serialOut : ~lastSdo;
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		mQ <= mclk;
		lastSdo <= sdoLine;
		riseCnt <= (rst || !syncPowerdownN) ? 12'h0 : riseCnt + {11'h0, mclk && !mQ};
	end
	adcr_readout #(.DECIM_N(3'h1)) i_dut (.clk(clk), .rst(rst), .sampleData(sampleData),
		.sampleValid(sampleValid), .sampleReady(sampleReady), .mclk(mclk), .csN(csN),
		.sclk(sclk), .syncPowerdownN(syncPowerdownN), .chainIn(chainIn),
		.readyStrobeN(readyStrobeN), .serialOut(serialOut), .serialOutEn(serialOutEn),
		.settled(settled));
	adcr_host_model u_host (.clk(clk), .strobeN(readyStrobeN), .sdoLine(sdoLine),
		.readEn(readEn), .nBits(nBits), .mclk(mclk), .csN(csN), .sclk(sclk),
		.chainIn(chainIn), .got(got), .readCount(readCount));
	function [23:0] word(input integer k);
		word = 24'h813579 + 24'h10eca3 * k[23:0];
	endfunction
	task check(input string what, input [31:0] seen, input [31:0] exp);
		checksDone = checksDone + 1;
		if (seen !== exp) begin
			errCount = errCount + 1;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task waitFall(input integer lim, output reg hit);
		integer n;
		reg p;
		hit = 1'b0;
		for (n = 0; n < lim && !hit; n = n + 1) begin
			p = readyStrobeN;
			@(posedge clk);
			hit = (p === 1'b1) && (readyStrobeN === 1'b0);
		end
		fallAt = riseCnt;
	endtask
	task readWord(input [5:0] bits, input [31:0] exp);
		reg hit;
		integer n;
		reg [7:0] c;
		c = readCount;
		nBits <= bits;
		readEn <= 1'b1;
		waitFall(30000, hit);
		check("readFall", hit, 1);
		for (n = 0; n < 400 && readCount === c; n = n + 1)
			@(posedge clk);
		check("word", got & ~(32'hffffffff << bits), exp);
	endtask
	task t_fill;
		for (i = 0; i < 17; i = i + 1) begin
			@(posedge clk);
			sampleValid <= 1'b1;
			sampleData <= word(i);
		end
		@(negedge clk);
		check("full", sampleReady, 0);
		check("idle", {readyStrobeN, settled}, 2'b10);
		@(posedge clk);
		sampleValid <= 1'b0;
		$display("t_fill done");
	endtask
	task t_settle;
		readWord(6'h18, {8'h0, word(0)});
		check("settle", fallAt, 592 * 1 + 2 + 1);
		check("settledRun", settled, 1);
		$display("t_settle done");
	endtask
	task t_stream;
		integer k, f;
		for (k = 1; k < 13; k = k + 1) begin
			f = fallAt;
			if (k < 12)
				readWord(6'h18, {8'h0, word(k)});
			else
				readWord(6'h1c, {4'h0, word(k), 4'hb});
			check("period", fallAt - f, 8 * 1);
		end
		$display("t_stream done");
	endtask
	task t_drain;
		reg hit;
		readEn <= 1'b0;
		for (i = 13; i < 17; i = i + 1) begin
			waitFall(400, hit);
			check("fall", hit, i < 16);
		end
		$display("t_drain done");
	endtask
	task t_pd;
		reg hit;
		@(posedge clk);
		sampleValid <= 1'b1;
		sampleData <= word(20);
		@(posedge clk);
		sampleData <= word(21);
		@(posedge clk);
		sampleValid <= 1'b0;
		waitFall(700, hit);
		check("pdFall", hit, 1);
		repeat (50) @(posedge clk);
		syncPowerdownN <= 1'b0;
		repeat (60) @(posedge clk);
		check("pdStrobe", {readyStrobeN, settled}, 2'b10);
		repeat (400) @(posedge clk);
		syncPowerdownN <= 1'b1;
		readWord(6'h18, {8'h0, word(21)});
		check("pdSettle", fallAt >= 595, 1);
		$display("t_pd done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_fill;
		t_settle;
		t_stream;
		t_drain;
		t_pd;
		stop_test;
	end
	initial begin
		#2000000;
		errCount = errCount + 1;
		stop_test;
	end
endmodule
